// ---- design/ssf_status.sv ----
// Status flag logic of the three-axis magnetic sensor
// Behaviour
// - Raise mag interrupt flag on measurement done
// - Clear it on command or I2C mag access
// - Clear it on IBI sent or status read
// - Temp flag: set done, clear command/I2C access
// - Clear temp flag on IBI or read
// - Motion flag: set detect, clear launch/IBI/read
// - Parity failure sets flag and requests IBI
// - Clear parity failure after its IBI
// - Fuse load complete after successful memory load
// - Self-test flag low when test passes
// - Mag ready cleared only by mag read
// - Temp ready cleared only by temp read
// - Pending code: none, meas, motion, protocol
// - Protocol error bit set on I3C error
// - Motion seen cleared by new launch write
// - Activity bit0 zero, bit1 measuring
// - Mag command bit self-clears at end
`timescale 1ns/1ps
module ssf_status
  import ssf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire ssf_pkg::ssf_access_type access,
  input wire ssf_pkg::ssf_event_type events,
  input wire logic i3c_mode,
  input wire logic selftest_fail,
  input wire logic meas_active,
  input wire logic ibi_sent,
  output logic [7:0] rd_data,
  output logic mag_capture_cmd,
  output logic temp_capture_cmd,
  output logic motion_detect_launch,
  output logic ibi_req,
  output logic [1:0] ibi_code
);
  import ssf_pkg::*;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  wire logic acc_read = access.valid && !access.write;
  wire logic acc_write = access.valid && access.write;
  wire logic acc_i2c = access.valid && !access.over_i3c;
  wire logic hit_mag = in_range(access.addr, ssf_mag_first_addr, ssf_mag_last_addr);
  wire logic hit_temp = access.addr == ssf_temp_addr;
  wire logic hit_primary = access.addr == ssf_status_primary_addr;
  wire logic hit_secondary = access.addr == ssf_status_secondary_addr;
  wire logic hit_control0 = access.addr == ssf_control0_addr;
  wire logic wr_control0 = acc_write && hit_control0;
  wire logic new_meas_cmd = wr_control0 && (access.wdata[ssf_cmd_mag_bit] || access.wdata[ssf_cmd_temp_bit]);
  wire logic new_launch = wr_control0 && access.wdata[ssf_cmd_motion_bit];
  wire logic rd_primary = acc_read && hit_primary;
  wire logic rd_secondary = acc_read && hit_secondary;

  // ------------------------------------------------------------
  // Primary status flags
  // ------------------------------------------------------------
  logic [ssf_primary_flags-1:0] flags;
  logic [ssf_primary_flags-1:0] flag_set;
  logic [ssf_primary_flags-1:0] flag_clr;
  logic [1:0] code;
  logic sent_meas;
  logic sent_motion;

  assign sent_meas = ibi_sent && (code == ssf_code_meas);
  assign sent_motion = ibi_sent && (code == ssf_code_motion);

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[ssf_mag_irq_bit] = events.mag_done;
    flag_clr[ssf_mag_irq_bit] = new_meas_cmd || (acc_i2c && hit_mag);
    if (sent_meas || rd_primary) begin
      flag_clr[ssf_mag_irq_bit] = 1'b1;
    end
    flag_set[ssf_temp_irq_bit] = events.temp_done;
    flag_clr[ssf_temp_irq_bit] = new_meas_cmd || (acc_i2c && hit_temp) || sent_meas || rd_primary;
    flag_set[ssf_motion_irq_bit] = events.motion;
    flag_clr[ssf_motion_irq_bit] = new_launch || sent_motion || rd_primary;
    flag_set[ssf_sync_tick_parity_fail_bit] = events.parity_fail;
    flag_clr[ssf_sync_tick_parity_fail_bit] = ibi_sent && flags[ssf_sync_tick_parity_fail_bit];
    flag_set[ssf_fuse_done_bit] = events.fuse_loaded;
    flag_clr[ssf_fuse_done_bit] = events.fuse_reload;
    flag_set[ssf_mag_ready_bit] = events.mag_done;
    flag_clr[ssf_mag_ready_bit] = acc_read && hit_mag;
    flag_set[ssf_temp_ready_bit] = events.temp_done;
    flag_clr[ssf_temp_ready_bit] = acc_read && hit_temp;
  end

  ssf_sticky #(
    .width(ssf_primary_flags)
  ) u_primary (
    .clk(clk),
    .rst_b(rst_b),
    .set(flag_set),
    .clr(flag_clr),
    .q(flags)
  );

  // ------------------------------------------------------------
  // Self-test flag and secondary status state
  // ------------------------------------------------------------
  logic selftest_flag;
  logic motion_seen;
  logic proto_err;
  wire logic next_motion_seen = events.motion || (motion_seen && !new_launch);
  wire logic next_proto_err = events.proto_err || (proto_err && !rd_secondary);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      selftest_flag <= 1'b0;
      motion_seen <= 1'b0;
      proto_err <= 1'b0;
    end else begin
      selftest_flag <= selftest_fail;
      motion_seen <= next_motion_seen;
      proto_err <= next_proto_err;
    end
  end

  // ------------------------------------------------------------
  // Measurement commands
  // ------------------------------------------------------------
  // Command bits fall at the end of their measurement; a new write wins
  wire logic next_mag_cmd = (wr_control0 && access.wdata[ssf_cmd_mag_bit]) ||
                            (mag_capture_cmd && !events.mag_done);
  wire logic next_temp_cmd = (wr_control0 && access.wdata[ssf_cmd_temp_bit]) ||
                             (temp_capture_cmd && !events.temp_done);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mag_capture_cmd <= 1'b0;
      temp_capture_cmd <= 1'b0;
      motion_detect_launch <= 1'b0;
    end else begin
      mag_capture_cmd <= next_mag_cmd;
      temp_capture_cmd <= next_temp_cmd;
      motion_detect_launch <= new_launch;
    end
  end

  // ------------------------------------------------------------
  // Pending interrupt code and in-band request
  // ------------------------------------------------------------
  // Protocol error outranks motion, motion outranks measurement
  assign code = proto_err ? ssf_code_proto :
                flags[ssf_motion_irq_bit] ? ssf_code_motion :
                (flags[ssf_mag_irq_bit] || flags[ssf_temp_irq_bit]) ? ssf_code_meas :
                ssf_code_none;

  // I2C has no in-band interrupt, so requests wait for I3C
  assign ibi_req = i3c_mode && ((code != ssf_code_none) || flags[ssf_sync_tick_parity_fail_bit]);
  assign ibi_code = code;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  wire logic [1:0] activity = (mag_capture_cmd || temp_capture_cmd || meas_active) ?
                              ssf_activity_busy : ssf_activity_idle;
  logic [7:0] primary_view;
  logic [7:0] secondary_view;

  always_comb begin
    primary_view = flags;
    primary_view[ssf_selftest_bit] = selftest_flag;
    secondary_view = ssf_status_reset;
    secondary_view[ssf_code_lsb +: 2] = code;
    secondary_view[ssf_motion_seen_bit] = motion_seen;
    secondary_view[ssf_proto_err_bit] = proto_err;
    secondary_view[ssf_activity_lsb +: 2] = activity;
  end

  // Value captured before the clear-on-read lands
  wire logic [7:0] next_rd_data = rd_primary ? primary_view :
                                  rd_secondary ? secondary_view :
                                  acc_read ? ssf_status_reset : rd_data;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= ssf_status_reset;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule // ssf_status

// ---- design/ssf_pkg.sv ----
// Package with constants and carriers of the sensor status flag block
package ssf_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ssf_mag_first_addr = 8'h00;
  localparam logic [7:0] ssf_mag_last_addr = 8'h08;
  localparam logic [7:0] ssf_temp_addr = 8'h09;
  localparam logic [7:0] ssf_status_primary_addr = 8'h18;
  localparam logic [7:0] ssf_status_secondary_addr = 8'h19;
  localparam logic [7:0] ssf_control0_addr = 8'h1b;
  localparam logic [7:0] ssf_status_reset = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  // Primary status
  localparam int ssf_mag_irq_bit = 0;
  localparam int ssf_temp_irq_bit = 1;
  localparam int ssf_motion_irq_bit = 2;
  localparam int ssf_sync_tick_parity_fail_bit = 3;
  localparam int ssf_fuse_done_bit = 4;
  localparam int ssf_selftest_bit = 5;
  localparam int ssf_mag_ready_bit = 6;
  localparam int ssf_temp_ready_bit = 7;
  localparam int ssf_primary_flags = 8;
  // Secondary status
  localparam int ssf_code_lsb = 0;
  localparam int ssf_motion_seen_bit = 2;
  localparam int ssf_proto_err_bit = 5;
  localparam int ssf_activity_lsb = 6;
  // Control 0
  localparam int ssf_cmd_mag_bit = 0;
  localparam int ssf_cmd_temp_bit = 1;
  localparam int ssf_cmd_motion_bit = 2;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] ssf_code_none = 2'h0;
  localparam logic [1:0] ssf_code_meas = 2'h1;
  localparam logic [1:0] ssf_code_motion = 2'h2;
  localparam logic [1:0] ssf_code_proto = 2'h3;
  localparam logic [1:0] ssf_activity_idle = 2'h0;
  localparam logic [1:0] ssf_activity_busy = 2'h2;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  // Register access reported by the bus protocol engine, one-cycle valid
  typedef struct packed {
    logic valid;
    logic write;
    logic over_i3c;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssf_access_type;

  // One-cycle events from the sensor core, same clock
  typedef struct packed {
    logic mag_done;
    logic temp_done;
    logic motion;
    logic parity_fail;
    logic fuse_loaded;
    logic fuse_reload;
    logic proto_err;
  } ssf_event_type;
endpackage

// ---- design/ssf_sticky.sv ----
// Bank of sticky flags in which a set beats a clear in the same cycle
`timescale 1ns/1ps
module ssf_sticky #(
  parameter int width = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [width-1:0] set,
  input wire logic [width-1:0] clr,
  output logic [width-1:0] q
);
  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (width < 1) begin : g_bad_width
    $error("ssf_sticky width must be at least one");
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  // Set wins so an event landing on the clearing access is never lost
  wire logic [width-1:0] next_q = (q & ~clr) | set;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // ssf_sticky

// ---- testbench/ssf_host.sv ----
// Host model that issues register accesses and acknowledges IBIs
`timescale 1ns/1ps
module ssf_host
  import ssf_pkg::*;
(
  input wire logic clk,
  input wire logic ibi_req,
  input wire logic ack_en,
  output ssf_pkg::ssf_access_type access,
  output logic ibi_sent
);
  initial begin
    access = '0;
    ibi_sent = 1'b0;
  end
  // One pulse per request; the gap cycle lets the clear land first
  always @(posedge clk) ibi_sent <= ack_en && ibi_req && !ibi_sent;
  task automatic acc(input logic w, input logic i, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) access <= {1'b1, w, i, a, d};
    // Released fields go inverted so a stale value never looks valid
    @(posedge clk) access <= {1'b0, ~access[17:0]};
  endtask
endmodule // ssf_host

// ---- testbench/ssf_status_chk.sv ----
// Port checks of the status flag block
`timescale 1ns/1ps
module ssf_status_chk
  import ssf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire ssf_pkg::ssf_access_type access,
  input wire ssf_pkg::ssf_event_type events,
  input wire logic i3c_mode,
  input wire logic mag_capture_cmd,
  input wire logic motion_detect_launch,
  input wire logic ibi_req,
  input wire logic [1:0] ibi_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_ctl_wr;
    access.valid && access.write && access.addr == ssf_control0_addr;
  endsequence
  sequence s_launch_wr;
    s_ctl_wr ##0 access.wdata[ssf_cmd_motion_bit];
  endsequence
  // A second launch write right behind the first stretches the pulse legally
  sequence s_no_launch_wr;
    !(access.valid && access.write && access.addr == ssf_control0_addr && access.wdata[ssf_cmd_motion_bit]);
  endsequence
  property p_no_i2c;
    !i3c_mode |-> !ibi_req;
  endproperty
  a_no_i2c: assert property (p_no_i2c) else $error("IBI in I2C mode");
  property p_code_req;
    i3c_mode && ibi_code != ssf_code_none |-> ibi_req;
  endproperty
  a_code_req: assert property (p_code_req) else $error("IBI not requested");
  property p_mag;
    events.mag_done |=> ibi_code != ssf_code_none;
  endproperty
  a_mag: assert property (p_mag) else $error("Mag flag not raised");
  property p_proto;
    events.proto_err |=> ibi_code == ssf_code_proto;
  endproperty
  a_proto: assert property (p_proto) else $error("Protocol code wrong");
  property p_parity;
    events.parity_fail && i3c_mode ##1 i3c_mode |-> ibi_req;
  endproperty
  a_parity: assert property (p_parity) else $error("Parity IBI missing");
  property p_cmd;
    s_ctl_wr ##0 access.wdata[ssf_cmd_mag_bit] |=> mag_capture_cmd;
  endproperty
  a_cmd: assert property (p_cmd) else $error("Mag command not set");
  property p_cmd_end;
    mag_capture_cmd && events.mag_done && !access.valid |=> !mag_capture_cmd;
  endproperty
  a_cmd_end: assert property (p_cmd_end) else $error("Mag command stuck");
  property p_launch;
    s_launch_wr ##1 s_no_launch_wr |-> motion_detect_launch ##1 !motion_detect_launch;
  endproperty
  a_launch: assert property (p_launch) else $error("Launch pulse wrong");
endmodule // ssf_status_chk
bind ssf_status ssf_status_chk chk_i (
  .clk(clk),
  .rst_b(rst_b),
  .access(access),
  .events(events),
  .i3c_mode(i3c_mode),
  .mag_capture_cmd(mag_capture_cmd),
  .motion_detect_launch(motion_detect_launch),
  .ibi_req(ibi_req),
  .ibi_code(ibi_code)
);

// ---- testbench/ssf_status_tb.sv ----
// Self-checking bench for the status flag block
`timescale 1ns/1ps
module ssf_status_tb;
  import ssf_pkg::*;
  localparam logic [7:0] s1 = ssf_status_primary_addr;
  localparam logic [7:0] s0 = ssf_status_secondary_addr;
  logic clk, rst_b, i3c_mode, selftest_fail, meas_active, ack_en, ibi_sent, ibi_req;
  logic mag_capture_cmd, temp_capture_cmd, motion_detect_launch;
  logic [1:0] ibi_code;
  logic [7:0] rd_data;
  ssf_access_type access;
  ssf_event_type events;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  ssf_status dut (
    .clk(clk),
    .rst_b(rst_b),
    .access(access),
    .events(events),
    .i3c_mode(i3c_mode),
    .selftest_fail(selftest_fail),
    .meas_active(meas_active),
    .ibi_sent(ibi_sent),
    .rd_data(rd_data),
    .mag_capture_cmd(mag_capture_cmd),
    .temp_capture_cmd(temp_capture_cmd),
    .motion_detect_launch(motion_detect_launch),
    .ibi_req(ibi_req),
    .ibi_code(ibi_code)
  );
  ssf_host host (.clk(clk), .ibi_req(ibi_req), .ack_en(ack_en), .access(access), .ibi_sent(ibi_sent));
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic i, input logic [7:0] e);
    host.acc(1'b0, i, a, 8'h00);
    #1 chk("rd_data", e, rd_data);
  endtask
  task automatic ev(input logic [6:0] v);
    @(posedge clk) events <= v;
    @(posedge clk) events <= '0;
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run is under 150 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rst_b, i3c_mode, selftest_fail, meas_active, ack_en} = '0;
    events = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(s1, 0, 8'h00);
    rd(s0, 0, 8'h00);
    ev(7'h04);
    rd(s1, 0, 8'h10);
    ev(7'h02);
    rd(s1, 0, 8'h00);
    host.acc(1'b1, 1'b0, ssf_control0_addr, 8'h01);
    rd(s0, 0, 8'h80);
    chk("mag_capture_cmd", 8'h01, {7'h00, mag_capture_cmd});
    ev(7'h40);
    chk("mag_capture_cmd", 8'h00, {7'h00, mag_capture_cmd});
    rd(s0, 0, 8'h01);
    chk("ibi_req", 8'h00, {7'h00, ibi_req});
    chk("ibi_code", 8'h01, {6'h00, ibi_code});
    rd(s1, 1, 8'h41);
    rd(s1, 1, 8'h40);
    rd(8'h00, 1, 8'h00);
    rd(s1, 1, 8'h00);
    ev(7'h40);
    rd(8'h08, 1, 8'h00);
    rd(s0, 0, 8'h01);
    rd(8'h08, 0, 8'h00);
    rd(s1, 0, 8'h00);
    ev(7'h40);
    host.acc(1'b1, 1'b0, ssf_control0_addr, 8'h02);
    rd(s1, 0, 8'h40);
    chk("temp_capture_cmd", 8'h01, {7'h00, temp_capture_cmd});
    ev(7'h20);
    chk("temp_capture_cmd", 8'h00, {7'h00, temp_capture_cmd});
    rd(s1, 0, 8'hc2);
    rd(s1, 0, 8'hc0);
    rd(8'h09, 0, 8'h00);
    rd(8'h00, 0, 8'h00);
    rd(s1, 0, 8'h00);
    ev(7'h20);
    host.acc(1'b1, 1'b0, ssf_temp_addr, 8'h00);
    rd(s1, 0, 8'h80);
    rd(8'h09, 1, 8'h00);
    ev(7'h10);
    rd(s0, 0, 8'h06);
    host.acc(1'b1, 1'b0, ssf_control0_addr, 8'h04);
    rd(s0, 0, 8'h00);
    rd(s1, 0, 8'h00);
    ev(7'h01);
    rd(s0, 0, 8'h23);
    rd(s0, 0, 8'h00);
    @(posedge clk) selftest_fail <= 1'b1;
    rd(s1, 0, 8'h20);
    @(posedge clk) selftest_fail <= 1'b0;
    rd(s1, 0, 8'h00);
    @(posedge clk) meas_active <= 1'b1;
    rd(s0, 0, 8'h80);
    @(posedge clk) meas_active <= 1'b0;
    i3c_mode <= 1'b1;
    ev(7'h08);
    chk("ibi_req", 8'h01, {7'h00, ibi_req});
    rd(s1, 1, 8'h08);
    @(posedge clk) ack_en <= 1'b1;
    repeat (3) @(posedge clk);
    rd(s1, 1, 8'h00);
    ev(7'h40);
    repeat (3) @(posedge clk);
    rd(s1, 1, 8'h40);
    rd(8'h00, 1, 8'h00);
    ev(7'h10);
    repeat (3) @(posedge clk);
    rd(s1, 1, 8'h00);
    rd(s0, 1, 8'h04);
    print_verdict();
  end
endmodule // ssf_status_tb
